// File: design/issc_io_decode.sv
// maps an i/o-instruction or data-space address onto the 64-entry i/o space
`timescale 1ns/1ps
module issc_io_decode (
    // address from the core
    input wire logic io_space_in,
    input wire logic [7:0] addr_in,
    // decoded result
    output logic [5:0] index_out,
    output logic valid_out,
    output logic bit_ok_out,
    output logic is_psc_out
);
    logic [7:0] ds_index;

    assign ds_index = addr_in - issc_pkg::DS_OFFSET;

    always_comb begin
        if (io_space_in) begin
            // i/o instructions use offsets 0x00..0x3F directly
            valid_out = (addr_in <= {2'h0, issc_pkg::IO_LAST});
            index_out = addr_in[5:0];
        end else begin
            // data-space address is the offset plus 0x20
            valid_out = (addr_in >= issc_pkg::DS_OFFSET) && (addr_in <= issc_pkg::DS_LAST);
            index_out = ds_index[5:0];
        end
        // only the low 32 registers take single-bit operations
        bit_ok_out = valid_out && (index_out <= issc_pkg::BIT_LAST);
        is_psc_out = valid_out && (index_out == issc_pkg::PSC_IO_OFFSET);
    end
endmodule // issc_io_decode

// File: design/issc_pkg.sv
// shared constants for the i/o space decoder and sleep control block
package issc_pkg;
    // i/o space layout
    localparam logic [5:0] IO_LAST = 6'h3F;
    localparam logic [5:0] BIT_LAST = 6'h1F;
    localparam logic [7:0] DS_OFFSET = 8'h20;
    localparam logic [7:0] DS_LAST = 8'h5F;
    // power and sleep control register
    localparam logic [5:0] PSC_IO_OFFSET = 6'h35;
    localparam logic [7:0] PSC_DS_ADDR = 8'h55;
    localparam logic [7:0] PSC_RESET = 8'h00;
    localparam int SLEEP_EN_POS = 7;
    localparam int SM_MSB = 6;
    localparam int SM_LSB = 4;
    // sleep mode codes
    localparam logic [2:0] SM_IDLE = 3'h0;
    localparam logic [2:0] SM_ADC_NR = 3'h1;
    localparam logic [2:0] SM_PWR_DOWN = 3'h2;
    localparam logic [2:0] SM_PWR_SAVE = 3'h3;
    localparam logic [2:0] SM_RSVD_A = 3'h4;
    localparam logic [2:0] SM_RSVD_B = 3'h5;
    localparam logic [2:0] SM_STANDBY = 3'h6;
    localparam logic [2:0] SM_EXT_STANDBY = 3'h7;
    // core access operations
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_WRITE = 3'h1;
    localparam logic [2:0] OP_BIT_SET = 3'h2;
    localparam logic [2:0] OP_BIT_CLEAR = 3'h3;
    localparam logic [2:0] OP_SKIP_ONE = 3'h4;
    localparam logic [2:0] OP_SKIP_ZERO = 3'h5;
endpackage

// File: design/issc_top.sv
// i/o space access engine with the power and sleep control register
// Summary of operation
// - power-down during a data-memory write lets it finish and keeps oscillator running
// - a reset during a data-memory write still lets that write finish
// - i/o instructions reach the i/o space at addresses 0x00 to 0x3F
// - data-space access to an i/o register uses its offset plus 0x20
// - bit set, clear and test-skip work on registers 0x00 to 0x1F only
// - bit set or clear rewrites the whole register, clearing flags that read one
// - the sleep instruction sleeps only while sleep enable, bit 7, is one
// - mode field bits 6:4 selects idle, noise reduction, power-down, save, standby
// - standby modes are available only with an external crystal or resonator
// - control register sits at i/o 0x35, data 0x55, resets to 0x00
`timescale 1ns/1ps
module issc_top (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // access request from the core
    input wire logic io_req_in,
    input wire logic [2:0] io_op_in,
    input wire logic io_space_in,
    input wire logic [7:0] io_addr_in,
    input wire logic [2:0] io_bit_in,
    input wire logic [7:0] io_wdata_in,
    // access answer to the core
    output logic io_done_out,
    output logic io_err_out,
    output logic io_skip_out,
    output logic [7:0] io_rdata_out,
    // peripheral register port
    output logic [5:0] per_index_out,
    output logic per_re_out,
    output logic per_we_out,
    output logic [7:0] per_wdata_out,
    input wire logic [7:0] per_rdata_in,
    // sleep control
    input wire logic sleep_instr_in,
    input wire logic wake_in,
    input wire logic ext_crystal_in,
    output logic sleep_active_out,
    output logic [2:0] sleep_mode_out,
    output logic osc_stop_out,
    // reset sequencing and data-memory write status
    input wire logic sys_reset_req_in,
    input wire logic nvm_busy_in,
    output logic core_reset_out,
    output logic nvm_reset_out
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RMW = 2'b10
    } issc_state_t;

    typedef struct packed {
        issc_state_t st;
        logic sleep_enable_bit;
        logic [2:0] sleep_mode_sel;
        logic [5:0] idx;
        logic [2:0] op;
        logic [2:0] bitn;
        logic done;
        logic err;
        logic skip;
        logic [7:0] rdata;
        logic per_re;
        logic per_we;
        logic [7:0] per_wdata;
        logic sleeping;
        logic [2:0] slp_mode;
        logic osc_stop;
        logic core_rst;
        logic nvm_rst;
    } issc_regs_t;

    localparam issc_regs_t REGS_RESET = '{
        st: ST_IDLE,
        sleep_enable_bit: issc_pkg::PSC_RESET[issc_pkg::SLEEP_EN_POS],
        sleep_mode_sel: issc_pkg::PSC_RESET[issc_pkg::SM_MSB:issc_pkg::SM_LSB],
        default: '0
    };

    issc_regs_t s_q;
    issc_regs_t s_d;
    logic [5:0] dec_index;
    logic dec_valid;
    logic dec_bit_ok;
    logic dec_is_psc;
    logic is_bitop;
    logic bad_op;
    logic mode_ok;
    logic [7:0] psc_value;
    logic [7:0] bit_mask;

    issc_io_decode u_decode (
        .io_space_in(io_space_in),
        .addr_in(io_addr_in),
        .index_out(dec_index),
        .valid_out(dec_valid),
        .bit_ok_out(dec_bit_ok),
        .is_psc_out(dec_is_psc)
    );

    assign is_bitop = (io_op_in == issc_pkg::OP_BIT_SET) || (io_op_in == issc_pkg::OP_BIT_CLEAR)
        || (io_op_in == issc_pkg::OP_SKIP_ONE) || (io_op_in == issc_pkg::OP_SKIP_ZERO);
    assign bad_op = (io_op_in > issc_pkg::OP_SKIP_ZERO);
    // low nibble is unused and always reads zero
    assign psc_value = {s_q.sleep_enable_bit, s_q.sleep_mode_sel, 4'h0};
    assign bit_mask = 8'h01 << s_q.bitn;

    // reserved codes never sleep; standby needs a crystal
    always_comb begin
        case (s_q.sleep_mode_sel)
            issc_pkg::SM_RSVD_A, issc_pkg::SM_RSVD_B: mode_ok = 1'b0;
            issc_pkg::SM_STANDBY, issc_pkg::SM_EXT_STANDBY: mode_ok = ext_crystal_in;
            default: mode_ok = 1'b1;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.err = 1'b0;
        s_d.skip = 1'b0;
        s_d.per_re = 1'b0;
        s_d.per_we = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                if (io_req_in) begin
                    s_d.idx = dec_index;
                    s_d.op = io_op_in;
                    s_d.bitn = io_bit_in;
                    if (!dec_valid || bad_op || (is_bitop && !dec_bit_ok)) begin
                        // bit operations above 0x1F are refused
                        s_d.done = 1'b1;
                        s_d.err = 1'b1;
                    end else if (dec_is_psc) begin
                        // own register answers locally
                        s_d.done = 1'b1;
                        if (io_op_in == issc_pkg::OP_WRITE) begin
                            s_d.sleep_enable_bit = io_wdata_in[issc_pkg::SLEEP_EN_POS];
                            s_d.sleep_mode_sel = io_wdata_in[issc_pkg::SM_MSB:issc_pkg::SM_LSB];
                        end else begin
                            s_d.rdata = psc_value;
                        end
                    end else if (io_op_in == issc_pkg::OP_WRITE) begin
                        s_d.per_we = 1'b1;
                        s_d.per_wdata = io_wdata_in;
                        s_d.done = 1'b1;
                    end else begin
                        s_d.per_re = 1'b1;
                        s_d.st = ST_RMW;
                    end
                end
            end
            ST_RMW: begin
                s_d.st = ST_IDLE;
                s_d.done = 1'b1;
                case (s_q.op)
                    issc_pkg::OP_READ: s_d.rdata = per_rdata_in;
                    issc_pkg::OP_BIT_SET: begin
                        // whole register goes back, so set flags are cleared
                        s_d.per_we = 1'b1;
                        s_d.per_wdata = per_rdata_in | bit_mask;
                    end
                    issc_pkg::OP_BIT_CLEAR: begin
                        s_d.per_we = 1'b1;
                        s_d.per_wdata = per_rdata_in & ~bit_mask;
                    end
                    issc_pkg::OP_SKIP_ONE: s_d.skip = per_rdata_in[s_q.bitn];
                    issc_pkg::OP_SKIP_ZERO: s_d.skip = !per_rdata_in[s_q.bitn];
                    default: s_d.err = 1'b1;
                endcase
            end
            default: s_d.st = ST_IDLE;
        endcase

        // sleep only with the enable bit set
        if (sleep_instr_in && !s_q.sleeping && s_q.sleep_enable_bit && mode_ok) begin
            s_d.sleeping = 1'b1;
            s_d.slp_mode = s_q.sleep_mode_sel;
            // a running write keeps the oscillator for the whole sleep
            s_d.osc_stop = (s_q.sleep_mode_sel == issc_pkg::SM_PWR_DOWN) && !nvm_busy_in;
        end else if (s_q.sleeping && wake_in) begin
            s_d.sleeping = 1'b0;
            s_d.osc_stop = 1'b0;
        end

        // the write engine is held out of reset until its write ends
        s_d.core_rst = sys_reset_req_in;
        s_d.nvm_rst = sys_reset_req_in && !nvm_busy_in;
        if (sys_reset_req_in) begin
            s_d.sleep_enable_bit = issc_pkg::PSC_RESET[issc_pkg::SLEEP_EN_POS];
            s_d.sleep_mode_sel = issc_pkg::PSC_RESET[issc_pkg::SM_MSB:issc_pkg::SM_LSB];
            s_d.sleeping = 1'b0;
            s_d.osc_stop = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= REGS_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign io_done_out = s_q.done;
    assign io_err_out = s_q.err;
    assign io_skip_out = s_q.skip;
    assign io_rdata_out = s_q.rdata;
    assign per_index_out = s_q.idx;
    assign per_re_out = s_q.per_re;
    assign per_we_out = s_q.per_we;
    assign per_wdata_out = s_q.per_wdata;
    assign sleep_active_out = s_q.sleeping;
    assign sleep_mode_out = s_q.slp_mode;
    assign osc_stop_out = s_q.osc_stop;
    assign core_reset_out = s_q.core_rst;
    assign nvm_reset_out = s_q.nvm_rst;

    osc_held_busy_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (sleep_instr_in && !sleep_active_out && nvm_busy_in) |=> !osc_stop_out)
        else $error("oscillator stopped while a data-memory write ran");
    nvm_reset_hold_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        nvm_busy_in |=> !nvm_reset_out)
        else $error("write engine reset during an active write");
    io_range_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (io_req_in && s_q.st == ST_IDLE && io_space_in && io_addr_in > 8'h3F) |=> io_err_out)
        else $error("i/o address above 0x3F accepted");
    ds_map_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (io_req_in && s_q.st == ST_IDLE && !io_space_in && io_op_in == issc_pkg::OP_WRITE
        && io_addr_in == 8'h38) |=> (per_we_out && per_index_out == 6'h18))
        else $error("data-space address not mapped to offset minus 0x20");
    bitop_range_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (io_req_in && s_q.st == ST_IDLE && is_bitop && dec_valid && dec_index > 6'h1F)
        |=> (io_done_out && io_err_out && !per_re_out))
        else $error("bit operation allowed above 0x1F");
    rmw_write_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (per_re_out && s_q.op == issc_pkg::OP_BIT_SET)
        |=> (per_we_out && per_wdata_out == ($past(per_rdata_in) | bit_mask)))
        else $error("bit set did not rewrite the whole register");
    sleep_gate_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(sleep_active_out) |-> ($past(s_q.sleep_enable_bit) && $past(sleep_instr_in)))
        else $error("sleep entered without sleep enable");
    standby_xtal_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        ($rose(sleep_active_out) && sleep_mode_out[2]) |-> $past(ext_crystal_in))
        else $error("standby entered without an external crystal");
    psc_low_zero_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (io_req_in && s_q.st == ST_IDLE && dec_is_psc && io_op_in == issc_pkg::OP_READ)
        |=> (io_rdata_out[3:0] == 4'h0 && io_done_out))
        else $error("unused control bits read non-zero");
endmodule // issc_top

// File: verification/issc_core_model.sv
// processor core model issuing i/o accesses and sleep instructions
`timescale 1ns/1ps
module issc_core_model (
    // clock
    input wire logic core_clk_in,
    // answer from the block
    input wire logic done_in,
    input wire logic err_in,
    input wire logic skip_in,
    input wire logic [7:0] rdata_in,
    // requests to the block
    output logic req_out,
    output logic [2:0] op_out,
    output logic space_out,
    output logic [7:0] addr_out,
    output logic [2:0] bit_out,
    output logic [7:0] wdata_out,
    output logic sleep_out
);
    logic timed_out = 1'b0;
    initial begin
        {req_out, op_out, space_out, addr_out, bit_out, wdata_out, sleep_out} = '0;
    end
    // request held for its taking edge only: a longer hold would be taken twice
    task automatic access(input logic [2:0] op, input logic sp, input logic [7:0] a,
        input logic [2:0] bt, input logic [7:0] wd, output logic e, output logic s,
        output logic [7:0] rd);
        int n;
        @(posedge core_clk_in);
        #1;
        {req_out, op_out, space_out, addr_out, bit_out, wdata_out} = {1'b1, op, sp, a, bt, wd};
        @(posedge core_clk_in);
        #1;
        req_out = 1'b0;
        for (n = 0; n < 4 && done_in !== 1'b1; n++) begin
            @(negedge core_clk_in);
        end
        timed_out = (done_in !== 1'b1);
        {e, s, rd} = {err_in, skip_in, rdata_in};
    endtask
    // callers keep the data-memory write idle unless probing the overlap
    task automatic sleep_pulse();
        @(posedge core_clk_in);
        #1;
        sleep_out = 1'b1;
        @(posedge core_clk_in);
        #1;
        sleep_out = 1'b0;
    endtask
endmodule // issc_core_model

// File: verification/tb_top.sv
// self-checking bench for the i/o space and sleep control block
`timescale 1ns/1ps
module tb_top;
    localparam logic [2:0] RD = issc_pkg::OP_READ;
    localparam logic [2:0] WR = issc_pkg::OP_WRITE;
    localparam logic [2:0] BS = issc_pkg::OP_BIT_SET;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req, sp, done, err, skip, p_re, p_we, slp, wake, xtal, active, osc, sys_rq, busy;
    logic core_rst, nvm_rst, e, s;
    logic [2:0] op, bt, mode, bop;
    logic [7:0] addr, wd, rdat, p_wd, p_rd, rd, exp;
    logic [5:0] p_idx;
    logic [7:0] mem [64];
    int mismatches = 0;
    int n_checks = 0;
    int seed = 32'h7762;
    int idx, b, m;

    always #4 core_clk_in = ~core_clk_in;
    // index 8 behaves as a write-one-to-clear flag register
    assign p_rd = mem[p_idx];
    always @(posedge core_clk_in) begin
        if (p_we === 1'b1) begin
            mem[p_idx] <= (p_idx == 6'h08) ? (mem[p_idx] & ~p_wd) : p_wd;
        end
    end

    issc_top i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .io_req_in(req),
        .io_op_in(op), .io_space_in(sp), .io_addr_in(addr), .io_bit_in(bt),
        .io_wdata_in(wd), .io_done_out(done), .io_err_out(err), .io_skip_out(skip),
        .io_rdata_out(rdat), .per_index_out(p_idx), .per_re_out(p_re), .per_we_out(p_we),
        .per_wdata_out(p_wd), .per_rdata_in(p_rd), .sleep_instr_in(slp), .wake_in(wake),
        .ext_crystal_in(xtal), .sleep_active_out(active), .sleep_mode_out(mode),
        .osc_stop_out(osc), .sys_reset_req_in(sys_rq), .nvm_busy_in(busy),
        .core_reset_out(core_rst), .nvm_reset_out(nvm_rst));
    issc_core_model u_core (.core_clk_in(core_clk_in), .done_in(done), .err_in(err),
        .skip_in(skip), .rdata_in(rdat), .req_out(req), .op_out(op), .space_out(sp),
        .addr_out(addr), .bit_out(bt), .wdata_out(wd), .sleep_out(slp));

    function automatic logic [7:0] bit_result(input logic [7:0] old, input int b, input int m);
        case (m)
            0: return old | (8'h01 << b);
            1: return old & ~(8'h01 << b);
            default: return old;
        endcase
    endfunction
    function automatic logic sleep_expect(input int m);
        if (!m[4] || m[2:0] == issc_pkg::SM_RSVD_A || m[2:0] == issc_pkg::SM_RSVD_B) return 1'b0;
        if (m[2:1] == 2'b11) return m[3];
        return 1'b1;
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic acc(input logic [2:0] o, input logic a_sp, input logic [7:0] a,
        input logic [2:0] bit_n, input logic [7:0] d);
        u_core.access(o, a_sp, a, bit_n, d, e, s, rd);
        if (u_core.timed_out) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    task automatic cycle();
        @(posedge core_clk_in);
        #1;
    endtask

    initial begin
        {wake, xtal, sys_rq, busy} = '0;
        for (idx = 0; idx < 64; idx++) mem[idx] = $random(seed);
        repeat (6) @(posedge core_clk_in);
        #1;
        rst_n_in = 1'b1;
        acc(RD, 1'b1, 8'h35, 3'h0, 8'h00);
        check("psc reset", rd, issc_pkg::PSC_RESET);
        acc(WR, 1'b0, 8'h55, 3'h0, 8'hFF);
        acc(RD, 1'b1, 8'h35, 3'h0, 8'h00);
        check("psc low bits", rd, 8'hF0);
        repeat (24) begin
            idx = $random(seed) & 63;
            if (idx == 8 || idx == 53) idx++;
            exp = $random(seed);
            acc(WR, 1'b1, 8'(idx), 3'h0, exp);
            acc(RD, 1'b0, 8'(idx + 32), 3'h0, 8'h00);
            check("data space read", rd, exp);
        end
        repeat (32) begin
            idx = $random(seed) & 31;
            if (idx == 8) idx = 9;
            b = $random(seed) & 7;
            m = $random(seed) & 3;
            exp = mem[idx];
            bop = BS + 3'(m);
            acc(bop, 1'b1, 8'(idx), 3'(b), 8'h00);
            // the rewrite lands in the model one edge after the done pulse
            cycle();
            if (m > 1) check("skip", {7'h0, s}, {7'h0, exp[b] ^ (m == 3)});
            check("bit op", mem[idx], bit_result(exp, b, m));
        end
        exp = mem[40];
        acc(BS, 1'b1, 8'h28, 3'h0, 8'h00);
        check("high bit op err", {7'h0, e}, 8'h01);
        check("high bit op mem", mem[40], exp);
        mem[8] = 8'h05;
        acc(BS, 1'b1, 8'h08, 3'h1, 8'h00);
        cycle();
        check("flag clear", mem[8], 8'h00);
        acc(RD, 1'b1, 8'h40, 3'h0, 8'h00);
        check("io range err", {7'h0, e}, 8'h01);
        acc(RD, 1'b0, 8'h1F, 3'h0, 8'h00);
        check("data range err", {7'h0, e}, 8'h01);
        exp = $random(seed);
        acc(WR, 1'b0, 8'h38, 3'h0, exp);
        cycle();
        check("data space write", mem[24], exp);
        for (m = 0; m < 32; m++) begin
            xtal = m[3];
            acc(WR, 1'b1, 8'h35, 3'h0, {m[4], m[2:0], 4'h0});
            u_core.sleep_pulse();
            check("sleep entry", {7'h0, active}, {7'h0, sleep_expect(m)});
            if (sleep_expect(m)) check("sleep mode", {5'h0, mode}, 8'(m[2:0]));
            check("osc stop", {7'h0, osc}, {7'h0, sleep_expect(m) && m[2:0] == 3'h2});
            wake = 1'b1;
            cycle();
            wake = 1'b0;
            cycle();
            check("woken", {7'h0, active}, 8'h00);
            acc(WR, 1'b1, 8'h35, 3'h0, 8'h00);
        end
        busy = 1'b1;
        acc(WR, 1'b0, 8'h55, 3'h0, 8'hA0);
        u_core.sleep_pulse();
        busy = 1'b0;
        repeat (3) cycle();
        check("busy power-down", {6'h0, active, osc}, 8'h02);
        busy = 1'b1;
        sys_rq = 1'b1;
        cycle();
        check("reset during write", {6'h0, core_rst, nvm_rst}, 8'h02);
        busy = 1'b0;
        cycle();
        check("reset after write", {6'h0, core_rst, nvm_rst}, 8'h03);
        sys_rq = 1'b0;
        cycle();
        acc(RD, 1'b0, 8'h55, 3'h0, 8'h00);
        check("psc after reset", rd, 8'h00);
        report_and_stop();
    end
endmodule // tb_top
